/* bench/ccs_clock_switch_sva.sv */
/* Checker for the clock switch ports.
 Assumes pready one cycle into the access phase and ce held high. */
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_switch_sva
	import ccs_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        osc_started,
	input wire logic        wake_irq,
	input wire logic        xtal_osc_en,
	input wire logic        cpu_halted
);
	logic [2:0] tsel_reg;
	logic       rd_stat;
	assign rd_stat = psel && penable && pready && !pwrite && paddr == OFF_STAT;
	// Shadow of the select, clamped like the register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			tsel_reg <= TSEL_RESET;
		else if (psel && penable && pready && pwrite && paddr == OFF_TSEL)
			tsel_reg <= (pwdata[2:0] > TSEL_MAX) ? TSEL_MAX : pwdata[2:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	stat_order_a: assert property (rd_stat |-> (prdata[4:0] & (prdata[4:0] + 5'h01)) == 5'h00)
		else $error("status bits out of order");
	stat_limit_a: assert property (rd_stat |-> (prdata[4:0] >> (tsel_reg + 3'h1)) == 5'h00)
		else $error("status beyond select");
	halt_no_osc_a: assert property (cpu_halted && !osc_started && !wake_irq |=> cpu_halted)
		else $error("wait ended before oscillation");
	xtal_stop_a: assert property ($fell(xtal_osc_en) |-> $past(pwrite && pready) || $past(pwrite && pready, 2))
		else $error("crystal stopped without write");
	cover property (rd_stat && prdata[4:0] == 5'h1f);
	cover property ($fell(xtal_osc_en));
	cover property ($fell(cpu_halted));
endmodule
`default_nettype wire

/* bench/testbench.sv */
/* Self-checking bench for the clock switch.
 Assumes STAB_BASE 2 and ce held high. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import ccs_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
	logic        osc_started, wake_irq, xtal_osc_en, cpu_halted;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	ccs_src_e    cpu_clk_src;
	int          n_errors, checked, seed, t, i;
	ccs_clock_switch #(.STAB_BASE(2)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_started(osc_started), .wake_irq(wake_irq),
		.cpu_clk_src(cpu_clk_src), .xtal_osc_en(xtal_osc_en), .cpu_halted(cpu_halted));
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task end_of_test;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// Request stands until pready is seen at a rising edge
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			n_errors++;
			end_of_test;
		end
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wait_stat(input logic [31:0] e);
		int k;
		apb(1'b0, OFF_STAT, 32'h0);
		for (k = 0; k < 300 && rd !== e; k++)
			apb(1'b0, OFF_STAT, 32'h0);
		if (k == 300)
		begin
			n_errors++;
			end_of_test;
		end
	endtask
	function automatic logic [31:0] therm(input int v);
		return (32'h1 << ((v > 4 ? 4 : v) + 1)) - 32'h1;
	endfunction
	initial
	begin
		{n_errors, checked, seed} = {32'h0, 32'h0, 32'd14639};
		{presetn, ce, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
		{osc_started, wake_irq, rd} = 34'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (5 + {$random(seed)} % 20) @(posedge pclk);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("stat_pre_osc", rd, 32'h0);
		apb(1'b1, OFF_MCM, 32'h1);
		osc_started <= 1'b1;
		wait_stat(therm(4));
		chk("stat_full", rd, therm(4));
		$display("reset release done");
		apb(1'b0, OFF_MCM, 32'h0);
		chk("mcs_xtal", rd, 32'h3);
		repeat (2) @(posedge pclk);
		chk("src_xtal", cpu_clk_src, SEL_XTAL);
		apb(1'b1, OFF_PCC, 32'h10);
		repeat (2) @(posedge pclk);
		chk("src_sub", cpu_clk_src, SEL_SUB);
		apb(1'b1, OFF_PCC, 32'h0);
		repeat (2) @(posedge pclk);
		chk("src_back", cpu_clk_src, SEL_XTAL);
		apb(1'b1, OFF_PCC, 32'h10);
		apb(1'b1, OFF_MCM, 32'h0);
		apb(1'b0, OFF_MCM, 32'h0);
		chk("mcs_clear", rd, 32'h0);
		apb(1'b1, OFF_MOC, 32'h80);
		repeat (3) @(posedge pclk);
		chk("xtal_on_sub", xtal_osc_en, 32'h1);
		apb(1'b1, OFF_PCC, 32'h90);
		repeat (3) @(posedge pclk);
		chk("xtal_off_sub", xtal_osc_en, 32'h0);
		apb(1'b1, OFF_MOC, 32'h0);
		apb(1'b1, OFF_PCC, 32'h0);
		repeat (2) @(posedge pclk);
		chk("src_ring", cpu_clk_src, SEL_RING);
		$display("subsystem stop done");
		for (i = 0; i < 6; i++)
		begin
			t = i == 0 ? 0 : i == 1 ? 7 : {$random(seed)} % 8;
			apb(1'b1, OFF_TSEL, t);
			apb(1'b0, OFF_TSEL, 32'h0);
			chk("tsel", rd, t > 4 ? 4 : t);
			apb(1'b1, OFF_STOP, 32'h1);
			@(negedge pclk);
			chk("halt_in_stop", cpu_halted, 32'h1);
			@(posedge pclk);
			osc_started <= 1'b0;
			wake_irq <= 1'b1;
			@(posedge pclk);
			wake_irq <= 1'b0;
			apb(1'b0, OFF_STAT, 32'h0);
			chk("stat_no_osc", rd, 32'h0);
			osc_started <= 1'b1;
			wait_stat(therm(t));
			repeat (600) @(posedge pclk);
			apb(1'b0, OFF_STAT, 32'h0);
			chk("stat_limit", rd, therm(t));
		end
		$display("stop release done");
		presetn <= 1'b0;
		osc_started <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_TSEL, 32'h0);
		chk("tsel_reset", rd, TSEL_RESET);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("stat_reset", rd, 32'h0);
		$display("mid reset done");
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped_err", err, 32'h1);
		chk("unmapped_rd", rd, 32'h0);
		end_of_test;
	end
endmodule
bind ccs_clock_switch ccs_clock_switch_sva sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.osc_started(osc_started), .wake_irq(wake_irq), .xtal_osc_en(xtal_osc_en), .cpu_halted(cpu_halted));
`default_nettype wire

/* common/ccs_pkg.sv */
/*
 * Package for the CPU clock source switch: register offsets, field
 * positions, reset values, state types and the carrier structs.
 * Assumes a 32-bit APB register bus and one 10 MHz clock.
 */
package ccs_pkg;

	localparam int unsigned CLK_PERIOD_NS = 100;

	// Register byte offsets
	localparam logic [7:0] OFF_PCC  = 8'h00;
	localparam logic [7:0] OFF_MCM  = 8'h04;
	localparam logic [7:0] OFF_MOC  = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_TSEL = 8'h10;
	localparam logic [7:0] OFF_STOP = 8'h14;
	localparam logic [7:0] OFF_MODE = 8'h18;

	// Field positions
	localparam int unsigned POS_MAIN_OSC_CONTROL = 7;
	localparam int unsigned POS_CPU_SUB_SELECT   = 4;
	localparam int unsigned POS_CRYSTAL_SRC_SEL  = 0;
	localparam int unsigned POS_MAIN_CLK_SEL_ST  = 1;
	localparam int unsigned POS_CRYSTAL_OSC_STOP = 7;
	localparam int unsigned POS_STOP_ENTER       = 0;

	// Stabilization status width and select reset value
	localparam int unsigned       STAB_BITS      = 5;
	localparam logic [2:0]        TSEL_RESET     = 3'h4;
	localparam logic [2:0]        TSEL_MAX       = 3'h4;
	// Base stabilization interval, first status bit; later ones grow by 4x
	localparam int unsigned       STAB_BASE_NS   = 1600;
	localparam int unsigned       STAB_BASE_CYC  = (STAB_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {SEL_RING, SEL_XTAL, SEL_SUB} ccs_src_e;
	typedef enum logic [1:0] {PM_RUN, PM_STOP, PM_WAIT} ccs_pm_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ccs_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccs_apb_rsp_s;

	typedef struct packed {
		logic                  main_osc_control;
		logic                  cpu_sub_select;
		logic                  crystal_src_sel;
		logic                  main_clk_sel_st;
		logic                  crystal_osc_stop;
		logic [2:0]            tsel;
		logic [STAB_BITS-1:0]  stab;
		logic [15:0]           cnt;
		ccs_pm_e               pm;
		ccs_src_e              src;
		logic                  xtal_en;
		logic                  cpu_halt;
		ccs_apb_rsp_s          rsp;
	} ccs_state_s;

endpackage

/* hdl/ccs_clock_switch.sv */
/*
 * CPU clock source switch: selects ring oscillator, crystal or subsystem
 * clock for the CPU, gates the crystal, counts crystal stabilization after
 * stop release, with registers on APB.
 * Reset release waits for the crystal like a stop release.
 * Assumes inputs synchronous to pclk and an oscillator-started flag from
 * the crystal pad cell.
 */
// Contract
// - On subsystem clock the crystal stops via main oscillator control; stop bit ignored.
// - Stabilization status bits set in order from the first and stay set until stop entry or a crystal stop in run.
// - Stabilization counting stops at the programmed select time after stop release.
// - Stop release wait excludes time before oscillation starts, reset or interrupt.
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_switch
	import ccs_pkg::*;
#(
	parameter int unsigned STAB_BASE = STAB_BASE_CYC
)(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         osc_started,
	input  wire logic         wake_irq,
	output ccs_src_e          cpu_clk_src,
	output logic              xtal_osc_en,
	output logic              cpu_halted
);

	// A zero base would give every status bit the same threshold
	if (STAB_BASE < 1)
	begin
		$error("STAB_BASE must be at least one cycle");
	end
	// Top threshold must fit the 16-bit counter
	if ((STAB_BASE << (2 * (STAB_BITS - 1))) > 32'h0000_ffff)
	begin
		$error("STAB_BASE too large for the 16-bit counter");
	end
	// Select clamp must stay inside the status width
	if (TSEL_MAX >= STAB_BITS)
	begin
		$error("TSEL_MAX outside the status width");
	end

	ccs_apb_req_s req;
	ccs_state_s   st_reg;
	ccs_state_s   st_next;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// Threshold of status bit idx: base times four to the idx, minus one
	function automatic logic [15:0] stab_limit(input logic [2:0] idx);
		stab_limit = 16'((STAB_BASE << (2 * int'(idx))) - 1);
	endfunction

	always_comb
	begin
		logic wr_ok;
		logic setup;
		logic xtal_stop_req;
		logic [2:0] lim_idx;
		logic [31:0] rd;
		logic [STAB_BITS-1:0] prev_set;

		wr_ok = 1'b0;
		setup = 1'b0;
		xtal_stop_req = 1'b0;
		lim_idx = 3'h0;
		rd = 32'h0000_0000;
		st_next = st_reg;
		// Bit i may only follow bit i-1; bit 0 has no predecessor
		prev_set = {st_reg.stab[STAB_BITS-2:0], 1'b1};

		// APB: pready one cycle into the access phase
		setup = req.psel && req.penable && !st_reg.rsp.pready;
		wr_ok = req.psel && req.penable && st_reg.rsp.pready && req.pwrite;
		st_next.rsp.pready = setup;
		st_next.rsp.pslverr = 1'b0;
		if (setup)
		begin
			case (req.paddr)
				OFF_PCC:
				begin
					rd[POS_MAIN_OSC_CONTROL] = st_reg.main_osc_control;
					rd[POS_CPU_SUB_SELECT] = st_reg.cpu_sub_select;
				end
				OFF_MCM:
				begin
					rd[POS_CRYSTAL_SRC_SEL] = st_reg.crystal_src_sel;
					rd[POS_MAIN_CLK_SEL_ST] = st_reg.main_clk_sel_st;
				end
				OFF_MOC:  rd[POS_CRYSTAL_OSC_STOP] = st_reg.crystal_osc_stop;
				OFF_STAT: rd[STAB_BITS-1:0] = st_reg.stab;
				OFF_TSEL: rd[2:0] = st_reg.tsel;
				OFF_STOP: rd = 32'h0000_0000;
				OFF_MODE: rd[1:0] = st_reg.src;
				default:  st_next.rsp.pslverr = 1'b1;
			endcase
			st_next.rsp.prdata = rd;
		end

		// Writes land at the edge that completes the transfer
		if (wr_ok)
		begin
			case (req.paddr)
				OFF_PCC:
				begin
					st_next.main_osc_control = req.pwdata[POS_MAIN_OSC_CONTROL];
					st_next.cpu_sub_select = req.pwdata[POS_CPU_SUB_SELECT];
				end
				OFF_MCM:  st_next.crystal_src_sel = req.pwdata[POS_CRYSTAL_SRC_SEL];
				OFF_MOC:  st_next.crystal_osc_stop = req.pwdata[POS_CRYSTAL_OSC_STOP];
				OFF_TSEL: st_next.tsel = (req.pwdata[2:0] > TSEL_MAX) ? TSEL_MAX : req.pwdata[2:0];
				OFF_STOP:
				begin
					if (req.pwdata[POS_STOP_ENTER])
						st_next.pm = PM_STOP;
				end
				default:  st_next.pm = st_next.pm;
			endcase
		end

		// Stop bit only counts when the CPU is off the subsystem clock
		xtal_stop_req = st_reg.cpu_sub_select ? st_reg.main_osc_control : st_reg.crystal_osc_stop;
		st_next.xtal_en = !xtal_stop_req && (st_reg.pm != PM_STOP);

		// Power mode sequencing: stop, stabilization wait, run
		case (st_reg.pm)
			PM_STOP:
			begin
				st_next.stab = '0;
				st_next.cnt = 16'h0000;
				if (wake_irq)
					st_next.pm = PM_WAIT;
			end
			PM_WAIT:
			begin
				lim_idx = st_reg.tsel;
				// Time before the oscillator starts is not counted
				if (osc_started && st_reg.xtal_en)
				begin
					if (st_reg.cnt != stab_limit(lim_idx))
						st_next.cnt = 16'(st_reg.cnt + 16'h0001);
					for (int i = 0; i < STAB_BITS; i++)
					begin
						// Thermometer: each bit needs the one before it
						if (i <= int'(lim_idx) && st_reg.cnt >= stab_limit(3'(i)) &&
							prev_set[i])
							st_next.stab[i] = 1'b1;
					end
					if (st_reg.stab[lim_idx])
						st_next.pm = PM_RUN;
				end
			end
			PM_RUN:
			begin
				// Crystal stopped in run: status and count clear to zero
				// Limitation: no recount in run; a restarted crystal needs a stop release
				if (!st_reg.xtal_en)
				begin
					st_next.stab = '0;
					st_next.cnt = 16'h0000;
				end
			end
			default: st_next.pm = PM_RUN;
		endcase

		// Crystal counts as selected only once stable and running
		st_next.main_clk_sel_st = st_reg.crystal_src_sel && st_reg.xtal_en &&
			st_reg.stab[st_reg.tsel] && (st_reg.pm == PM_RUN);

		// Subsystem select wins; crystal only once reported as selected
		if (st_reg.cpu_sub_select)
			st_next.src = SEL_SUB;
		else if (st_reg.main_clk_sel_st)
			st_next.src = SEL_XTAL;
		else
			st_next.src = SEL_RING;

		// Halt in stop, and in the stabilization wait while the CPU is still on the crystal
		st_next.cpu_halt = (st_next.pm == PM_STOP) ||
			(st_next.pm == PM_WAIT && st_reg.src == SEL_XTAL);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Reset release starts in the wait state, like a stop release
			st_reg <= '0;
			st_reg.tsel <= TSEL_RESET;
			st_reg.pm <= PM_WAIT;
			st_reg.src <= SEL_RING;
		end
		else if (ce)
			st_reg <= st_next;
	end

	// Every output is a register bit, nothing combinational
	assign prdata      = st_reg.rsp.prdata;
	assign pready      = st_reg.rsp.pready;
	assign pslverr     = st_reg.rsp.pslverr;
	assign cpu_clk_src = st_reg.src;
	assign xtal_osc_en = st_reg.xtal_en;
	assign cpu_halted  = st_reg.cpu_halt;

endmodule
`default_nettype wire
